// File: rtl/ssp_pkg.sv
// Package: shared constants and types for the suspend / management / serial packet block.
// Assumes a single 200 MHz clock that is also the serial bit clock.
package ssp_pkg;

   // ------------------------------------------------------------
   // Clock
   // ------------------------------------------------------------
   localparam int SSP_CLK_MHZ = 200;

   // ------------------------------------------------------------
   // Serial packet framing
   // ------------------------------------------------------------
   localparam int SSP_PKT_W = 8;
   localparam logic SSP_IDLE_LEVEL = 1'h1;
   localparam logic SSP_START_LEVEL = 1'h0;
   localparam logic SSP_STOP_LEVEL = 1'h1;

   // ------------------------------------------------------------
   // Reset values of the configuration bits
   // ------------------------------------------------------------
   localparam logic SSP_RST_PIN_ENABLE = 1'h0;
   localparam logic SSP_RST_FULL_SUSPEND = 1'h0;

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SSP_SUS_IDLE = 2'b00,
      SSP_SUS_DRAIN = 2'b01,
      SSP_SUS_ASLEEP = 2'b10
   } ssp_sus_state_t;

   typedef enum logic [1:0] {
      SSP_TX_IDLE = 2'b00,
      SSP_TX_START = 2'b01,
      SSP_TX_DATA = 2'b10,
      SSP_TX_STOP = 2'b11
   } ssp_tx_state_t;

endpackage : ssp_pkg

// File: rtl/ssp_pkt_if.sv
// Interface: word handshake and serial line between the top and the packet shifter.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ssp_pkt_if #(parameter int PKT_W = ssp_pkg::SSP_PKT_W);
   logic valid;
   logic ready;
   logic [PKT_W-1:0] data;
   logic line;

   modport src (output valid, output data, input ready, input line);
   modport sink (input valid, input data, output ready, output line);
endinterface : ssp_pkt_if
`default_nettype wire

// File: rtl/ssp_serial_tx.sv
// Serial packet shifter: one word out as start bit, data bits LSB first, stop bit.
// Assumes the bit clock is the block clock, one bit per edge.
`timescale 1ns/1ps
`default_nettype none
module ssp_serial_tx
   import ssp_pkg::*;
#(
   parameter int PKT_W = SSP_PKT_W
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   ssp_pkt_if.sink pkt
);

   ssp_tx_state_t state_ff;
   logic [PKT_W-1:0] shift_ff;
   logic [$clog2(PKT_W+1)-1:0] cnt_ff;
   logic line_ff;

   assign pkt.ready = (state_ff == SSP_TX_IDLE);
   assign pkt.line = line_ff;

   // ------------------------------------------------------------
   // Framing sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_ff <= SSP_TX_IDLE;
         shift_ff <= '0;
         cnt_ff <= '0;
         line_ff <= SSP_IDLE_LEVEL;
      end else begin
         case (state_ff)
            SSP_TX_IDLE: begin
               line_ff <= SSP_IDLE_LEVEL;
               if (pkt.valid) begin
                  shift_ff <= pkt.data;
                  line_ff <= SSP_START_LEVEL;
                  state_ff <= SSP_TX_START;
               end
            end
            SSP_TX_START: begin
               line_ff <= shift_ff[0];
               shift_ff <= shift_ff >> 1;
               cnt_ff <= ($clog2(PKT_W+1))'(PKT_W - 1);
               state_ff <= SSP_TX_DATA;
            end
            SSP_TX_DATA: begin
               if (cnt_ff == '0) begin
                  line_ff <= SSP_STOP_LEVEL;
                  state_ff <= SSP_TX_STOP;
               end else begin
                  line_ff <= shift_ff[0];
                  shift_ff <= shift_ff >> 1;
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
            default: begin
               line_ff <= SSP_IDLE_LEVEL;
               state_ff <= SSP_TX_IDLE;
            end
         endcase
      end
   end

endmodule : ssp_serial_tx
`default_nettype wire

// File: rtl/ssp_top.sv
// Top: management interrupt entry, suspend handshake, clock-stop selection, serial packet out.
// Assumes clk_i is the system input clock; pins are asynchronous and synchronised here,
// core status and configuration writes come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Level-sensitive management interrupt enters management state
// - Drain instruction, pending work, bus cycles first
// - Suspend request ignored until enable bit set
// - Two depths: core clocks or all clocks
// - Acknowledge once suspended, by request or halt
// - Status packets sent serially on one wire
// - Bit clock is the system input clock
module ssp_top
   import ssp_pkg::*;
#(
   parameter int PKT_W = SSP_PKT_W
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic mgmt_interrupt_n_i,
   input wire logic suspend_request_n_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_suspend_pin_enable_i,
   input wire logic cfg_full_suspend_i,
   input wire logic core_busy_i,
   input wire logic halt_exec_i,
   input wire logic wake_i,
   input wire logic mgmt_resume_i,
   input wire logic pkt_valid_i,
   input wire logic [PKT_W-1:0] pkt_data_i,
   output logic pkt_ready_o,
   output logic system_management_state_o,
   output logic drain_req_o,
   output logic suspend_ack_n_o,
   output logic suspend_ack_n_oe_n_o,
   output logic core_clk_stop_o,
   output logic all_clk_stop_o,
   output logic ext_clk_stop_ok_o,
   output logic cfg_suspend_pin_enable_o,
   output logic cfg_full_suspend_o,
   output logic serial_packet_out_o
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Pull-up reset value keeps a floating request inactive.
   logic [1:0] smi_sync_ff;
   logic [1:0] suspend_request_n_sync_ff;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         smi_sync_ff <= 2'h3;
         suspend_request_n_sync_ff <= 2'h3;
      end else begin
         smi_sync_ff <= {smi_sync_ff[0], mgmt_interrupt_n_i};
         suspend_request_n_sync_ff <= {suspend_request_n_sync_ff[0], suspend_request_n_i};
      end
   end

   logic smi_act;
   logic suspend_request_n_act;
   assign smi_act = ~smi_sync_ff[1];
   assign suspend_request_n_act = ~suspend_request_n_sync_ff[1];

   // ------------------------------------------------------------
   // Configuration bits
   // ------------------------------------------------------------
   logic pin_enable_ff;
   logic full_suspend_ff;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pin_enable_ff <= SSP_RST_PIN_ENABLE;
         full_suspend_ff <= SSP_RST_FULL_SUSPEND;
      end else if (cfg_wr_i) begin
         pin_enable_ff <= cfg_suspend_pin_enable_i;
         full_suspend_ff <= cfg_full_suspend_i;
      end
   end

   assign cfg_suspend_pin_enable_o = pin_enable_ff;
   assign cfg_full_suspend_o = full_suspend_ff;

   // ------------------------------------------------------------
   // Management state
   // ------------------------------------------------------------
   // The input is a level: while it is still low, a resume is ignored and the state stays set.
   logic smm_ff;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         smm_ff <= 1'h0;
      end else if (smi_act) begin
         smm_ff <= 1'h1;
      end else if (mgmt_resume_i) begin
         smm_ff <= 1'h0;
      end
   end

   assign system_management_state_o = smm_ff;

   // ------------------------------------------------------------
   // Suspend sequencer
   // ------------------------------------------------------------
   ssp_sus_state_t sus_state_ff;
   ssp_sus_state_t nxt_sus_state;
   logic by_halt_ff;
   logic req_ok;

   assign req_ok = pin_enable_ff & suspend_request_n_act;

   always_comb begin
      nxt_sus_state = sus_state_ff;
      case (sus_state_ff)
         SSP_SUS_IDLE: begin
            if (req_ok || halt_exec_i) begin
               nxt_sus_state = SSP_SUS_DRAIN;
            end
         end
         SSP_SUS_DRAIN: begin
            // Work in flight must retire before any clock stops
            if (!core_busy_i) begin
               nxt_sus_state = SSP_SUS_ASLEEP;
            end
         end
         SSP_SUS_ASLEEP: begin
            if (wake_i || (!by_halt_ff && !req_ok)) begin
               nxt_sus_state = SSP_SUS_IDLE;
            end
         end
         default: begin
            nxt_sus_state = SSP_SUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sus_state_ff <= SSP_SUS_IDLE;
      end else begin
         sus_state_ff <= nxt_sus_state;
      end
   end

   // Remember the cause; a halt-caused sleep only ends on a wake event
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         by_halt_ff <= 1'h0;
      end else if (sus_state_ff == SSP_SUS_IDLE && nxt_sus_state == SSP_SUS_DRAIN) begin
         by_halt_ff <= ~req_ok;
      end
   end

   // ------------------------------------------------------------
   // Acknowledge and clock-stop outputs
   // ------------------------------------------------------------
   logic ack_ff;
   logic core_stop_ff;
   logic all_stop_ff;

   // Acknowledge and core stop share one decision so they always change on the same edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_ff <= 1'h0;
      end else begin
         ack_ff <= (nxt_sus_state == SSP_SUS_ASLEEP);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         core_stop_ff <= 1'h0;
      end else begin
         core_stop_ff <= (nxt_sus_state == SSP_SUS_ASLEEP);
      end
   end

   // Depth follows the config bit every cycle asleep; software should change it only while awake
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         all_stop_ff <= 1'h0;
      end else begin
         all_stop_ff <= (nxt_sus_state == SSP_SUS_ASLEEP) & full_suspend_ff;
      end
   end

   assign drain_req_o = (sus_state_ff == SSP_SUS_DRAIN);
   assign suspend_ack_n_o = ~ack_ff;
   // Pin floats from reset until software enables it
   assign suspend_ack_n_oe_n_o = ~pin_enable_ff;
   assign core_clk_stop_o = core_stop_ff;
   assign all_clk_stop_o = all_stop_ff;
   // Tells the system when its clock may be halted; it must not stop it otherwise
   assign ext_clk_stop_ok_o = ack_ff & all_stop_ff;

   // ------------------------------------------------------------
   // Serial packet link
   // ------------------------------------------------------------
   // No buffer: the source is held off through pkt_ready_o while a frame is out.
   ssp_pkt_if #(.PKT_W(PKT_W)) pkt_bus ();

   assign pkt_bus.valid = pkt_valid_i;
   assign pkt_bus.data = pkt_data_i;
   assign pkt_ready_o = pkt_bus.ready;

   // Shifter runs on clk_i, so the bit clock is the system input clock
   ssp_serial_tx #(
      .PKT_W(PKT_W)
   ) ssp_serial_tx_inst (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pkt(pkt_bus)
   );

   assign serial_packet_out_o = pkt_bus.line;

endmodule : ssp_top
`default_nettype wire

// File: verification/ssp_assertions.sv
// Checker for ssp_top: timing relations between the pins, handshakes and serial line.
// Assumes the top's ports only; attached by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module ssp_assertions (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic mgmt_interrupt_n_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_suspend_pin_enable_i,
   input wire logic cfg_full_suspend_i,
   input wire logic core_busy_i,
   input wire logic halt_exec_i,
   input wire logic pkt_valid_i,
   input wire logic pkt_ready_o,
   input wire logic system_management_state_o,
   input wire logic drain_req_o,
   input wire logic suspend_ack_n_o,
   input wire logic suspend_ack_n_oe_n_o,
   input wire logic core_clk_stop_o,
   input wire logic all_clk_stop_o,
   input wire logic ext_clk_stop_ok_o,
   input wire logic cfg_suspend_pin_enable_o,
   input wire logic cfg_full_suspend_o,
   input wire logic serial_packet_out_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Five samples cover the two synchroniser stages and the state register
   property p_smm; !mgmt_interrupt_n_i [*5] |-> system_management_state_o; endproperty
   property p_oe; suspend_ack_n_oe_n_o == ($past(cfg_wr_i) ? !$past(cfg_suspend_pin_enable_i)
      : $past(suspend_ack_n_oe_n_o)); endproperty
   property p_cfg; cfg_wr_i |=> cfg_suspend_pin_enable_o == $past(cfg_suspend_pin_enable_i)
      && cfg_full_suspend_o == $past(cfg_full_suspend_i); endproperty
   property p_refuse; $rose(drain_req_o) |-> cfg_suspend_pin_enable_o || $past(halt_exec_i); endproperty
   property p_drain; $fell(suspend_ack_n_o) |-> $past(drain_req_o && !core_busy_i); endproperty
   property p_ack; drain_req_o && !core_busy_i |=> !suspend_ack_n_o && core_clk_stop_o; endproperty
   property p_depth; $rose(core_clk_stop_o) |-> all_clk_stop_o == cfg_full_suspend_o; endproperty
   property p_extok; ext_clk_stop_ok_o == (!suspend_ack_n_o && all_clk_stop_o)
      && (!ext_clk_stop_ok_o || $past(cfg_full_suspend_o)); endproperty
   property p_frame; pkt_valid_i && pkt_ready_o |=> !serial_packet_out_o && !pkt_ready_o
      ##1 !pkt_ready_o [*8] ##1 !pkt_ready_o ##1 pkt_ready_o; endproperty
   property p_stop; $rose(pkt_ready_o) |-> $past(serial_packet_out_o) && serial_packet_out_o; endproperty
   a_smm: assert property (p_smm) else $error("management state not entered");
   a_oe: assert property (p_oe) else $error("acknowledge drive enable wrong");
   a_cfg: assert property (p_cfg) else $error("config bits not loaded");
   a_refuse: assert property (p_refuse) else $error("suspend request honoured while disabled");
   a_drain: assert property (p_drain) else $error("suspend entered while core busy");
   a_ack: assert property (p_ack) else $error("acknowledge or core stop missing after drain");
   a_depth: assert property (p_depth) else $error("suspend depth wrong");
   a_extok: assert property (p_extok) else $error("external clock stop flag wrong");
   a_frame: assert property (p_frame) else $error("start bit or busy span wrong");
   a_stop: assert property (p_stop) else $error("stop bit or idle level wrong");
   c_smm: cover property ($rose(system_management_state_o));
   c_full: cover property ($rose(ext_clk_stop_ok_o));
   c_pkt: cover property (pkt_valid_i && pkt_ready_o);
endmodule : ssp_assertions
bind ssp_top ssp_assertions ssp_assertions_inst (.*);
`default_nettype wire

// File: verification/ssp_rx_model.sv
// Companion receiver: decodes the serial packet line on the same system clock.
// Assumes one bit per clock, frame as start 0, data LSB first, stop 1.
`timescale 1ns/1ps
`default_nettype none
module ssp_rx_model
   import ssp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic line_i,
   output logic [SSP_PKT_W-1:0] word_o,
   output logic got_o,
   output logic stop_ok_o
);
   int cnt;
   // No clock line: the receiver samples on the system clock
   always @(posedge clk_i) begin
      got_o <= 1'h0;
      if (!rst_n_i) begin
         cnt <= 0;
      end else if (cnt == 0) begin
         if (line_i == SSP_START_LEVEL) cnt <= 1;
      end else if (cnt <= SSP_PKT_W) begin
         word_o <= {line_i, word_o[SSP_PKT_W-1:1]};
         cnt <= cnt + 1;
      end else begin
         stop_ok_o <= (line_i === SSP_STOP_LEVEL);
         got_o <= 1'h1;
         cnt <= 0;
      end
   end
endmodule : ssp_rx_model
`default_nettype wire

// File: verification/suspend_smi_serial_packet_test.sv
// Testbench for ssp_top with the companion receiver on its serial line.
// Assumes inputs change 1 ns after each rising edge of a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module suspend_smi_serial_packet_test;
   import ssp_pkg::*;
   logic clk_i = 0, rst_n_i = 0, mgmt_n = 1, req_n = 1, cfg_wr = 0, cfg_en = 0, cfg_full = 0;
   logic busy = 0, halt = 0, wake = 0, resume = 0, valid = 0;
   logic [7:0] data = 8'h00, rx_word;
   logic ready, system_management_state, drain, ack_n, oe_n, core_stop, all_stop, ext_ok, en_rb, full_rb, line, got, stop_ok;
   int miscompares = 0, n_checks = 0;
   always #2.5 clk_i = ~clk_i;
   ssp_top ssp_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .mgmt_interrupt_n_i(mgmt_n),
      .suspend_request_n_i(req_n), .cfg_wr_i(cfg_wr), .cfg_suspend_pin_enable_i(cfg_en),
      .cfg_full_suspend_i(cfg_full), .core_busy_i(busy), .halt_exec_i(halt), .wake_i(wake),
      .mgmt_resume_i(resume), .pkt_valid_i(valid), .pkt_data_i(data), .pkt_ready_o(ready),
      .system_management_state_o(system_management_state), .drain_req_o(drain), .suspend_ack_n_o(ack_n),
      .suspend_ack_n_oe_n_o(oe_n), .core_clk_stop_o(core_stop), .all_clk_stop_o(all_stop),
      .ext_clk_stop_ok_o(ext_ok), .cfg_suspend_pin_enable_o(en_rb), .cfg_full_suspend_o(full_rb),
      .serial_packet_out_o(line));
   ssp_rx_model ssp_rx_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .line_i(line), .word_o(rx_word),
      .got_o(got), .stop_ok_o(stop_ok));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task cyc(input int n); repeat (n) @(posedge clk_i); #1; endtask : cyc
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic pulse(ref logic s); s = 1; cyc(1); s = 0; endtask : pulse
   task cfg(input logic en, input logic full); cfg_en = en; cfg_full = full; pulse(cfg_wr); endtask : cfg
   task stop_test;
      if (miscompares == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_mgmt;
      mgmt_n = 0; cyc(6);
      chk("smm set", 1, system_management_state);
      pulse(resume); cyc(2);
      chk("smm held while active", 1, system_management_state);
      mgmt_n = 1; cyc(4); pulse(resume); cyc(2);
      chk("smm cleared", 0, system_management_state);
   endtask : t_mgmt
   task t_refuse;
      chk("ack floats", 1, oe_n);
      req_n = 0; cyc(8);
      chk("drain ignored", 0, drain);
      chk("ack idle", 1, ack_n);
      req_n = 1; cyc(4);
   endtask : t_refuse
   task t_suspend_request_n(input logic full);
      cfg(1, full); busy = 1;
      chk("ack driven", 0, oe_n);
      chk("enable readback", 1, en_rb);
      chk("depth readback", full, full_rb);
      req_n = 0; cyc(6);
      chk("drain", 1, drain);
      chk("ack while busy", 1, ack_n);
      busy = 0; cyc(3);
      chk("ack", 0, ack_n);
      chk("core stop", 1, core_stop);
      chk("all stop", full, all_stop);
      chk("ext stop ok", full, ext_ok);
      req_n = 1; cyc(6);
      chk("ack released", 1, ack_n);
   endtask : t_suspend_request_n
   task t_halt;
      pulse(halt); cyc(3);
      chk("halt ack", 0, ack_n);
      cyc(4);
      chk("halt stays", 0, ack_n);
      pulse(wake); cyc(3);
      chk("wake ack", 1, ack_n);
   endtask : t_halt
   task t_pkt(input logic [7:0] w);
      int i;
      valid = 1; data = w;
      for (i = 0; i < 20 && ready !== 1'h1; i++) cyc(1);
      cyc(1); valid = 0; data = ~w;
      chk("busy after take", 0, ready);
      for (i = 0; i < 20 && got !== 1'h1; i++) cyc(1);
      chk("rx frame seen", 1, got);
      chk("rx word", w, rx_word);
      chk("rx stop", 1, stop_ok);
      chk("line idle", SSP_IDLE_LEVEL, line);
   endtask : t_pkt
   initial begin
      #1; cyc(12); rst_n_i = 1; cyc(1);
      chk("reset ack", 1, ack_n);
      t_mgmt();
      t_refuse();
      t_suspend_request_n(0);
      t_suspend_request_n(1);
      t_halt();
      t_pkt(8'ha5);
      t_pkt(8'h01);
      t_pkt(8'h80);
      stop_test();
   end
   initial begin
      #20000;
      miscompares++;
      stop_test();
   end
endmodule : suspend_smi_serial_packet_test
`default_nettype wire
